/* rtl/ptb_pin_filter.sv */
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pins are asynchronous to ref_clk
// Notes: Output level moves only when stages two and three agree

`timescale 1ns/10ps
`default_nettype none

module ptb_pin_filter (
  input wire logic ref_clk,          // System clock
  input wire logic rst,              // Synchronous reset, active high
  input wire logic [1:0] pinIn,      // Raw asynchronous pins
  output var logic [1:0] pinLevel    // Filtered levels
);

  // One synchroniser per pin
  for (genvar i = 0; i < 2; i++) begin : g_pin
    logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

    // Stage one feeds only stage two, never a gate
    always_comb begin
      lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    end

    // Plain register chain
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        lvl_q <= 1'b0;
      end else begin
        s1_q <= pinIn[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        lvl_q <= lvl_d;
      end
    end

    assign pinLevel[i] = lvl_q;
  end

endmodule

`default_nettype wire

/* rtl/ptb_pkg.sv */
// Purpose: Shared constants for the periodic timebase block
// Assumes: One 8-bit control register on a plain strobe port
// Notes: Tap tables hold log2 of each divide value

package ptb_pkg;

  // Bus and counter widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W = 22;

  // Register map
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Field positions in periodic_tick_control
  localparam int BANK_BIT = 0;
  localparam int RUN_BIT = 1;
  localparam int IE_BIT = 2;
  localparam int ACK_BIT = 3;
  localparam int TAP_LSB = 4;
  localparam int TAP_MSB = 6;
  localparam int FLAG_BIT = 7;

  // log2 of divide 32768, 8192, 2048, 128, 64, 32, 16, 8
  localparam logic [4:0] TAP_LOG_BANK0 [8] = '{5'h0F, 5'h0D, 5'h0B, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03};
  // log2 of divide 4194304, 1048576, 262144, 16384, 8192, 4096, 2048, 1024
  localparam logic [4:0] TAP_LOG_BANK1 [8] = '{5'h16, 5'h14, 5'h12, 5'h0E, 5'h0D, 5'h0C, 5'h0B, 5'h0A};

  // Counter bit whose rising edge marks a rollover at the chosen tap
  function automatic logic [4:0] tapBit(input logic bank, input logic [2:0] sel);
    logic [4:0] lg;
    lg = bank ? TAP_LOG_BANK1[sel] : TAP_LOG_BANK0[sel];
    return lg - 5'h01;
  endfunction

  // Full divide value at the chosen tap
  function automatic logic [CNT_W:0] tapDivide(input logic bank, input logic [2:0] sel);
    logic [4:0] lg;
    lg = bank ? TAP_LOG_BANK1[sel] : TAP_LOG_BANK0[sel];
    return (CNT_W + 1)'(1) << lg;
  endfunction

endpackage

/* rtl/ptb_timebase.sv */
// Purpose: Periodic timebase with selectable divider tap and rollover flag
// Assumes: Divider source clocks are far slower than ref_clk (under a quarter of its rate)
// Notes: Source clock edges are counted, the divider itself runs on ref_clk
//
// Local design decisions: the strobed register port and the register offsets.

`timescale 1ns/10ps
`default_nettype none

module ptb_timebase
  import ptb_pkg::*;
(
  input wire logic ref_clk,                // System clock, 10 MHz
  input wire logic rst,                    // Synchronous reset, active high
  input wire logic [ADDR_W-1:0] regAddr,   // Register address
  input wire logic [DATA_W-1:0] regWdata,  // Write data
  input wire logic regWr,                  // Write strobe, one cycle
  input wire logic regRd,                  // Read strobe, one cycle
  output var logic [DATA_W-1:0] regRdata,  // Read data, cycle after strobe
  input wire logic externalClock,          // External clock pin
  input wire logic internalClock,          // Internally generated clock
  input wire logic extClockGenOn,          // External clock generator enabled
  input wire logic waitMode,               // Processor in wait
  input wire logic stopMode,               // Processor in stop
  input wire logic oscKeepInStop,          // Oscillator kept on in stop
  output var logic irqReq                  // Rollover interrupt request, level
);

  // Control fields
  logic runQ, runD;
  logic ieQ, ieD;
  logic bankQ, bankD;
  logic [2:0] tapQ, tapD;
  logic flagQ, flagD;
  logic irqQ, irqD;
  logic [DATA_W-1:0] rdataQ, rdataD;

  // Divider state
  logic [CNT_W-1:0] cntQ, cntD;
  logic [CNT_W-1:0] cntInc;
  logic srcPrevQ, srcPrevD;
  logic [1:0] pinLevel;
  logic srcLevel;
  logic srcTick;
  logic countOk;
  logic rollEv;
  logic [4:0] rollBit;

  // Bus decode
  logic accessOk;
  logic ctrlSel;
  logic ctrlWr;
  logic ackWr;

  // Both clocks come from outside ref_clk, so each is filtered first
  ptb_pin_filter u_pins (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinIn({externalClock, internalClock}),
    .pinLevel(pinLevel)
  );

  // Source select and edge detect; a mux switch may cost one stray tick
  always_comb begin
    srcLevel = extClockGenOn ? pinLevel[1] : pinLevel[0];
    srcTick = srcLevel & ~srcPrevQ;
    srcPrevD = srcLevel;
  end

  // Bus access is shut off in both low power modes
  always_comb begin
    accessOk = ~waitMode & ~stopMode;
    ctrlSel = (regAddr == CTRL_OFFSET);
    ctrlWr = regWr & ctrlSel & accessOk;
    ackWr = ctrlWr & regWdata[ACK_BIT];
  end

  // Divider runs unless stop mode has taken the oscillator away
  always_comb begin
    countOk = runQ & (~stopMode | oscKeepInStop);
    cntInc = cntQ + CNT_W'(1);
    rollBit = tapBit(bankQ, tapQ);
    // Rising edge of the tap bit gives half period first, full after
    rollEv = srcTick & countOk & ~cntQ[rollBit] & cntInc[rollBit];
  end

  // Counter next value
  always_comb begin
    if (!runQ) begin
      cntD = '0;
    end else if (srcTick && countOk) begin
      cntD = cntInc;
    end else begin
      cntD = cntQ;
    end
  end

  // Control register next values; tap is not guarded, software keeps it still
  always_comb begin
    runD = runQ;
    ieD = ieQ;
    bankD = bankQ;
    tapD = tapQ;
    if (ctrlWr) begin
      runD = regWdata[RUN_BIT];
      ieD = regWdata[IE_BIT];
      bankD = regWdata[BANK_BIT];
      tapD = regWdata[TAP_MSB:TAP_LSB];
    end
  end

  // Flag: a rollover in the acknowledge cycle wins over the clear
  always_comb begin
    flagD = rollEv | (flagQ & ~ackWr);
    irqD = flagD & ieD;
  end

  // Read data; acknowledge reads as zero, unmapped or blocked reads zero
  always_comb begin
    rdataD = '0;
    if (regRd && ctrlSel && accessOk) begin
      rdataD[FLAG_BIT] = flagQ;
      rdataD[TAP_MSB:TAP_LSB] = tapQ;
      rdataD[ACK_BIT] = 1'b0;
      rdataD[IE_BIT] = ieQ;
      rdataD[RUN_BIT] = runQ;
      rdataD[BANK_BIT] = bankQ;
    end
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      runQ <= CTRL_RESET[RUN_BIT];
      ieQ <= CTRL_RESET[IE_BIT];
      bankQ <= CTRL_RESET[BANK_BIT];
      tapQ <= CTRL_RESET[TAP_MSB:TAP_LSB];
      flagQ <= CTRL_RESET[FLAG_BIT];
      irqQ <= 1'b0;
      rdataQ <= '0;
      cntQ <= '0;
      srcPrevQ <= 1'b0;
    end else begin
      runQ <= runD;
      ieQ <= ieD;
      bankQ <= bankD;
      tapQ <= tapD;
      flagQ <= flagD;
      irqQ <= irqD;
      rdataQ <= rdataD;
      cntQ <= cntD;
      srcPrevQ <= srcPrevD;
    end
  end

  assign regRdata = rdataQ;
  assign irqReq = irqQ;

  // Checks; the helper logic below feeds only these

  default clocking cb @(posedge ref_clk);
  endclocking

  default disable iff (rst);

  // Helper: source ticks since the last rollover or since run was set
  logic [CNT_W:0] sinceQ, sinceD;
  logic seenQ, seenD;
  logic [CNT_W:0] divNow;

  // Helper next values
  always_comb begin
    divNow = tapDivide(bankQ, tapQ);
    sinceD = sinceQ;
    seenD = seenQ;
    if (!runQ) begin
      sinceD = '0;
      seenD = 1'b0;
    end else if (rollEv) begin
      sinceD = '0;
      seenD = 1'b1;
    end else if (srcTick && countOk) begin
      sinceD = sinceQ + (CNT_W + 1)'(1);
    end
  end

  // Helper registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sinceQ <= '0;
      seenQ <= 1'b0;
    end else begin
      sinceQ <= sinceD;
      seenQ <= seenD;
    end
  end

  // Steps of an acknowledge, of a blocked access and of a run start
  sequence ackNoRoll;
    ackWr && !rollEv;
  endsequence

  sequence blockedWrite;
    regWr && ctrlSel && (waitMode || stopMode);
  endsequence

  sequence zeroAckWrite;
    ctrlWr && !regWdata[ACK_BIT] && flagQ;
  endsequence

  sequence runStart;
    ctrlWr && regWdata[RUN_BIT] && !runQ;
  endsequence

  // Rollover sets the flag on the next edge
  flag_set_a: assert property (rollEv |=> flagQ)
    else $error("rollover did not set the flag");

  // Request follows flag and enable
  irq_level_a: assert property (##1 (irqReq == (flagQ && ieQ)))
    else $error("interrupt request disagrees with flag and enable");

  // Acknowledge clears the flag and the request
  ack_clear_a: assert property (ackNoRoll |=> !flagQ && !irqReq)
    else $error("acknowledge did not clear the flag");

  // Writing zero to acknowledge keeps the flag
  ack_zero_a: assert property (zeroAckWrite |=> flagQ)
    else $error("zero acknowledge changed the flag");

  // Acknowledge bit always reads zero
  ack_reads_a: assert property (regRd |=> !regRdata[ACK_BIT])
    else $error("acknowledge bit read as one");

  // Period at the tap after the first rollover
  tap_period_a: assert property (rollEv && seenQ |-> sinceQ == divNow - (CNT_W + 1)'(1))
    else $error("rollover spacing differs from divide value");

  // First rollover at half the period
  half_first_a: assert property (rollEv && !seenQ |-> sinceQ == (divNow >> 1) - (CNT_W + 1)'(1))
    else $error("first rollover not at half period");

  // Stopped divider sits at zero
  hold_zero_a: assert property (!runQ |=> cntQ == '0)
    else $error("divider not held at zero");

  // Clearing run leaves the flag alone
  run_clear_a: assert property (runQ && ctrlWr && !regWdata[RUN_BIT] && !ackWr && !rollEv |=>
    flagQ == $past(flagQ))
    else $error("clearing run changed the flag");

  // Enable and run come out of reset cleared
  reset_clear_a: assert property (@(posedge ref_clk) disable iff (1'b0) rst |=> !ieQ && !runQ && !flagQ)
    else $error("reset left control bits set");

  // Enable bit reads back what was written
  // The idle cycle between write and read matches a master that leaves a gap
  ie_readback_a: assert property (ctrlWr ##1 !ctrlWr ##1 (regRd && ctrlSel && accessOk) |=>
    regRdata[IE_BIT] == $past(regWdata[IE_BIT], 3))
    else $error("interrupt enable read back wrong");

  // Blocked writes leave run, enable, bank and tap as they were
  wait_block_a: assert property (blockedWrite |=> $stable({runQ, ieQ, bankQ, tapQ}))
    else $error("write landed during a low power mode");

  // Stop without oscillator freezes the divider
  stop_freeze_a: assert property (stopMode && !oscKeepInStop && runQ |=> cntQ == $past(cntQ))
    else $error("divider moved in stop without oscillator");

  // Wait mode keeps counting on source ticks
  wait_count_a: assert property (waitMode && !stopMode && runQ && srcTick |=> cntQ == $past(cntInc))
    else $error("divider idle during wait");

  // Setting run starts the divider from zero
  run_start_a: assert property (runStart |=> cntQ == '0 && runQ)
    else $error("divider did not start from zero");

  // Read data fall back to zero once the read cycle is over
  rdata_idle_a: assert property (!regRd |=> regRdata == '0)
    else $error("read data not idle at zero");

  // A read during a low power mode returns zero
  blocked_read_a: assert property (regRd && !accessOk |=> regRdata == '0)
    else $error("read answered during a low power mode");

  // A read returns every field at its place
  read_fields_a: assert property (regRd && ctrlSel && accessOk |=>
    regRdata == {$past(flagQ), $past(tapQ), 1'b0, $past(ieQ), $past(runQ), $past(bankQ)})
    else $error("read data fields misplaced");

  // Only an acknowledge takes a pending flag away
  flag_hold_a: assert property (flagQ && !ackWr |=> flagQ)
    else $error("flag cleared without acknowledge");

  // Only a rollover raises the flag
  flag_source_a: assert property (!flagQ && !rollEv |=> !flagQ)
    else $error("flag set without rollover");

  // A write stores tap, bank and run as given
  field_write_a: assert property (ctrlWr |=>
    tapQ == $past(regWdata[TAP_MSB:TAP_LSB]) && bankQ == $past(regWdata[BANK_BIT]) && runQ == $past(regWdata[RUN_BIT]))
    else $error("control write not stored");

  // A write stores the interrupt enable
  ie_write_a: assert property (ctrlWr |=> ieQ == $past(regWdata[IE_BIT]))
    else $error("interrupt enable not stored");

  // No request while the enable is clear
  irq_gate_a: assert property (!ieQ |-> !irqReq)
    else $error("request raised with enable clear");

  // Kept oscillator lets the divider count in stop
  keep_count_a: assert property (stopMode && oscKeepInStop && runQ && srcTick |=>
    cntQ == $past(cntQ) + CNT_W'(1))
    else $error("divider idle in stop with oscillator kept");

  // Counter moves only on source ticks
  idle_hold_a: assert property (runQ && !srcTick |=> cntQ == $past(cntQ))
    else $error("divider moved without a source tick");

  // A blocked acknowledge leaves the flag pending
  blocked_ack_a: assert property (regWr && ctrlSel && regWdata[ACK_BIT] && !accessOk && flagQ |=> flagQ)
    else $error("acknowledge landed during a low power mode");

  // Stop without oscillator raises no new flag
  stop_no_roll_a: assert property (stopMode && !oscKeepInStop |=> !$rose(flagQ))
    else $error("flag rose in stop without oscillator");

  // A source tick lasts a single cycle
  one_tick_a: assert property (srcTick |=> !srcTick)
    else $error("source tick longer than one cycle");

endmodule

`default_nettype wire

/* verif/periodic_timebase_interrupt_bench.sv */
// Purpose: Self-checking bench for the periodic timebase
// Assumes: Source periods of 6 and 8 ref_clk cycles
// Notes: The longest taps are left out to keep the run short
`timescale 1ns/10ps
`default_nettype none
module periodic_timebase_interrupt_bench;
  import ptb_pkg::*;
  localparam int PI = 6;
  localparam int PE = 8;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic extClockGenOn = 1'h0;
  logic waitMode = 1'h0;
  logic stopMode = 1'h0;
  logic oscKeepInStop = 1'h0;
  logic internalClock, externalClock, irqReq, rdPend = 1'h0, b;
  logic [DATA_W-1:0] regRdata, d;
  logic [2:0] s;
  logic [7:0] expQ[$];
  logic [3:0] tapTab [7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF, 4'hE};
  int divTab [7] = '{128, 64, 32, 16, 8, 1024, 2048};
  int nFail = 0, checksDone = 0, seed = 54, cyc = 0, n, t0, t1, p;

  // Clock and cycle count
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  ptb_src_model #(.HALF_INT(PI / 2), .HALF_EXT(PE / 2)) src (.ref_clk(ref_clk),
    .internalClock(internalClock), .externalClock(externalClock));
  ptb_timebase dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .externalClock(externalClock),
    .internalClock(internalClock), .extClockGenOn(extClockGenOn), .waitMode(waitMode),
    .stopMode(stopMode), .oscKeepInStop(oscKeepInStop), .irqReq(irqReq));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD %0t saw %0h want %0h", $time, seen, exp);
    end
  endtask

  task automatic endSim();
    if (nFail == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One bus cycle; a read notes its expected data for the monitor
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regWr <= wr;
    regRd <= !wr;
    regAddr <= a;
    regWdata <= v;
    if (!wr) expQ.push_back(v);
    @(posedge ref_clk);
    regWr <= 1'h0;
    regRd <= 1'h0;
  endtask

  // Sampled on the falling edge, where the request has settled; the first look
  // comes half a cycle on, so a request that the last edge lowered is not taken as live
  task automatic waitIrq(input int lim, output int cnt);
    cnt = 0;
    @(negedge ref_clk);
    while (irqReq !== 1'h1 && cnt < lim) begin
      @(negedge ref_clk);
      cnt++;
    end
  endtask

  task automatic irqIs(input logic e);
    @(negedge ref_clk);
    check({31'h0, irqReq}, {31'h0, e});
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rdPend) check({24'h0, regRdata}, {24'h0, expQ.pop_front()});
    rdPend <= regRd;
  end

  // Hang guard at 60k cycles, well beyond the expected 40k
  initial begin
    #6000000;
    nFail++;
    endSim();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'h0;
    bus(1'h0, CTRL_OFFSET, 8'h00);
    bus(1'h1, 4'h5, 8'hFF);
    bus(1'h0, 4'h5, 8'h00);
    bus(1'h0, CTRL_OFFSET, 8'h00);
    // Tap timing: first rollover near half, then the exact period
    for (int i = 0; i < 7; i++) begin
      b = tapTab[i][3];
      s = tapTab[i][2:0];
      p = b ? PE : PI;
      bus(1'h1, CTRL_OFFSET, {1'h0, s, 1'h0, 1'h1, 1'h0, b});
      extClockGenOn <= b;
      bus(1'h1, CTRL_OFFSET, {1'h0, s, 1'h1, 1'h1, 1'h1, b});
      t0 = cyc;
      waitIrq(divTab[i] * p * 2, n);
      t1 = cyc;
      check(32'((t1 - t0 >= (divTab[i] / 2 - 1) * p) && (t1 - t0 <= divTab[i] / 2 * p + 8)), 32'h1);
      bus(1'h1, CTRL_OFFSET, {1'h0, s, 1'h1, 1'h1, 1'h1, b});
      waitIrq(divTab[i] * p * 2, n);
      check(32'(cyc - t1), 32'(divTab[i] * p));
    end
    // Random field values, stopped so the tap may move
    bus(1'h1, CTRL_OFFSET, 8'h08);
    extClockGenOn <= 1'h0;
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed)) & 8'h7D;
      bus(1'h1, CTRL_OFFSET, d);
      bus(1'h0, CTRL_OFFSET, d & 8'h77);
    end
    // Flag, enable gating and acknowledge
    bus(1'h1, CTRL_OFFSET, 8'h7E);
    waitIrq(200, n);
    check(32'(n < 200), 32'h1);
    bus(1'h1, CTRL_OFFSET, 8'h70);
    irqIs(1'h0);
    bus(1'h0, CTRL_OFFSET, 8'hF0);
    bus(1'h1, CTRL_OFFSET, 8'h74);
    irqIs(1'h1);
    bus(1'h1, CTRL_OFFSET, 8'h7C);
    irqIs(1'h0);
    waitIrq(300, n);
    check(32'(n), 32'd300);
    // Stop mode with and without the oscillator kept on
    bus(1'h1, CTRL_OFFSET, 8'h7E);
    stopMode <= 1'h1;
    waitIrq(300, n);
    check(32'(n), 32'd300);
    bus(1'h0, CTRL_OFFSET, 8'h00);
    oscKeepInStop <= 1'h1;
    waitIrq(200, n);
    check(32'(n < 200), 32'h1);
    bus(1'h1, CTRL_OFFSET, 8'h7E);
    irqIs(1'h1);
    @(posedge ref_clk);
    stopMode <= 1'h0;
    oscKeepInStop <= 1'h0;
    // Wait mode: counting goes on, register is shut
    bus(1'h1, CTRL_OFFSET, 8'h7E);
    waitMode <= 1'h1;
    bus(1'h0, CTRL_OFFSET, 8'h00);
    bus(1'h1, CTRL_OFFSET, 8'h00);
    waitIrq(200, n);
    check(32'(n < 200), 32'h1);
    @(posedge ref_clk);
    waitMode <= 1'h0;
    bus(1'h0, CTRL_OFFSET, 8'hF6);
    // Software stops the divider before an idle stop
    bus(1'h1, CTRL_OFFSET, 8'h7C);
    stopMode <= 1'h1;
    waitIrq(100, n);
    check(32'(n), 32'd100);
    @(posedge ref_clk);
    stopMode <= 1'h0;
    bus(1'h0, CTRL_OFFSET, 8'h74);
    repeat (3) @(posedge ref_clk);
    endSim();
  end
endmodule
`default_nettype wire

/* verif/ptb_src_model.sv */
// Purpose: Source clock model standing in for the clock generator
// Assumes: Both source clocks are derived from ref_clk counts
// Notes: Free running, as oscillators are; phases of three cycles or more
`timescale 1ns/10ps
`default_nettype none
module ptb_src_model #(
  parameter int HALF_INT = 3,
  parameter int HALF_EXT = 4
) (
  input wire logic ref_clk,        // System clock
  output var logic internalClock,  // Internal source clock
  output var logic externalClock   // External source clock
);
  int cntI = 0;
  int cntE = 0;
  // Distinct rates so the bench can tell which source drives the divider
  always @(posedge ref_clk) begin
    cntI <= (cntI == 2 * HALF_INT - 1) ? 0 : cntI + 1;
    cntE <= (cntE == 2 * HALF_EXT - 1) ? 0 : cntE + 1;
  end
  assign internalClock = (cntI < HALF_INT);
  assign externalClock = (cntE < HALF_EXT);
endmodule
`default_nettype wire
